/* File: design/laser_status_ctrl.sv */
// Laser enable gating, health status outputs and lamp blink patterns
//
// Summary of operation
// - Laser ok low whenever any fault active
// - Temperature ok high unless over temperature or in reset
// - Ready lamp flashes during over temperature
// - Voltage ok low on under or over voltage
// - Power lamp repeats one or two blinks
// - Enable high lights ready lamp yellow
// - Enable gates command pulses to RF drive
`timescale 1ns/1ps
`default_nettype none
module laser_status_ctrl #(
  parameter int unsigned BLINK_CYCLES = laser_status_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Controller inputs
  input  wire logic laser_enable,
  input  wire logic pwm_command,
  // Internal sensors
  input  wire logic over_temp,
  input  wire logic under_volt,
  input  wire logic over_volt,
  // Drive and status outputs
  output logic      rf_drive,
  output logic      laser_ok,
  output logic      temp_ok,
  output logic      volt_ok,
  // Lamps
  output logic      ready_lamp,
  output logic      power_lamp
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [1:0] synced;

  input_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({laser_enable, pwm_command}),
    .sync_out (synced)
  );

  logic en_s;
  logic cmd_s;
  assign en_s  = synced[1];
  assign cmd_s = synced[0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] tick_cnt;
    logic        phase;
    logic [2:0]  slot;
    logic        rf_drive;
    logic        laser_ok;
    logic        temp_ok;
    logic        volt_ok;
    logic        ready_lamp;
    logic        power_lamp;
  } ctrl_s;

  ctrl_s state;
  ctrl_s next_state;

  logic       tick;
  logic [2:0] blinks;

  assign tick   = (state.tick_cnt == 32'(BLINK_CYCLES - 1));
  assign blinks = over_volt ? laser_status_pkg::OVER_BLINKS : laser_status_pkg::UNDER_BLINKS;

  always_comb
  begin
    next_state = state;
    // Blink time base: each slot is an on and an off half
    next_state.tick_cnt = tick ? 32'h0 : state.tick_cnt + 32'h1;
    if (tick)
    begin
      next_state.phase = ~state.phase;
      if (state.phase)
        next_state.slot = (state.slot == laser_status_pkg::PATTERN_SLOTS - 3'h1) ? 3'h0 : state.slot + 3'h1;
    end
    next_state.rf_drive = en_s & cmd_s;
    next_state.temp_ok  = ~over_temp;
    next_state.volt_ok  = ~(under_volt | over_volt);
    next_state.laser_ok = ~(over_temp | under_volt | over_volt);
    if (over_temp)
      next_state.ready_lamp = ~state.phase;
    else
      next_state.ready_lamp = en_s;
    if (under_volt | over_volt)
      next_state.power_lamp = ~state.phase && (state.slot < blinks);
    else
      next_state.power_lamp = 1'b1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign rf_drive   = state.rf_drive;
  assign laser_ok   = state.laser_ok;
  assign temp_ok    = state.temp_ok;
  assign volt_ok    = state.volt_ok;
  assign ready_lamp = state.ready_lamp;
  assign power_lamp = state.power_lamp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence en_cmd_high;
    laser_enable && pwm_command;
  endsequence

  sequence flash_edge;
    (tick && over_temp) ##1 over_temp;
  endsequence

  rf_pass_a: assert property (en_cmd_high |-> ##3 rf_drive)
    else $error("command not passed while enabled");
  rf_block_a: assert property (!laser_enable |-> ##3 !rf_drive)
    else $error("command passed while disabled");
  ok_fault_a: assert property ((!temp_ok || !volt_ok) |-> !laser_ok)
    else $error("laser ok high during fault");
  ok_temp_a: assert property (over_temp |=> !temp_ok)
    else $error("temperature ok high in over temperature");
  ok_volt_a: assert property ((under_volt || over_volt) |=> !volt_ok)
    else $error("voltage ok high in voltage fault");
  laser_ok_a: assert property (!(over_temp || under_volt || over_volt) |=> laser_ok)
    else $error("laser ok low with no fault");
  ready_en_a: assert property ((!over_temp && !$past(over_temp) && synced[1]) |=> ready_lamp)
    else $error("ready lamp dark while enabled");
  ready_flash_a: assert property (flash_edge |=> ready_lamp != $past(ready_lamp))
    else $error("ready lamp not flashing");
  power_blink_a: assert property ((over_volt && state.slot == 3'h3) |=> !power_lamp)
    else $error("power lamp lit outside blink slots");

  // ---------------------------------------------------------------
  // Checks: synchroniser and command gating
  // ---------------------------------------------------------------
  sequence cmd_single_pulse;
    (laser_enable && pwm_command) ##1 (laser_enable && !pwm_command);
  endsequence

  sync_en_a: assert property (laser_enable |-> ##2 en_s)
    else $error("enable not through synchroniser in two cycles");
  sync_hold_a: assert property (!laser_enable |-> ##2 !en_s)
    else $error("enable release not through synchroniser in two cycles");
  sync_cmd_a: assert property (!pwm_command |-> ##2 !cmd_s)
    else $error("command not through synchroniser in two cycles");
  rf_source_a: assert property (rf_drive |-> $past(en_s) && $past(cmd_s))
    else $error("drive pulse without synchronised enable and command");
  rf_gate_a: assert property (!en_s |=> !rf_drive)
    else $error("drive pulse while synchronised enable low");
  rf_pulse_a: assert property (cmd_single_pulse |-> ##2 rf_drive ##1 !rf_drive)
    else $error("single command pulse not passed as one drive pulse");

  // ---------------------------------------------------------------
  // Checks: status recovery and cause
  // ---------------------------------------------------------------
  ok_all_a: assert property ((temp_ok && volt_ok) |-> laser_ok)
    else $error("laser ok low with temperature and voltage good");
  ok_lamp_a: assert property ((over_temp || under_volt || over_volt) |=> !laser_ok)
    else $error("laser ok high while a fault is active");
  temp_clear_a: assert property (!over_temp |=> temp_ok)
    else $error("temperature ok low with no over temperature");
  volt_clear_a: assert property (!(under_volt || over_volt) |=> volt_ok)
    else $error("voltage ok low with supply in limits");
  temp_cause_a: assert property ((!temp_ok && !$past(rst)) |-> $past(over_temp))
    else $error("temperature ok low without over temperature");
  volt_cause_a: assert property ((!volt_ok && !$past(rst)) |-> ($past(under_volt) || $past(over_volt)))
    else $error("voltage ok low without voltage fault");

  // ---------------------------------------------------------------
  // Checks: lamp patterns
  // ---------------------------------------------------------------
  sequence enable_pin_high;
    laser_enable ##2 !over_temp;
  endsequence

  sequence enable_pin_low;
    !laser_enable ##2 !over_temp;
  endsequence

  sequence blink_start;
    (under_volt || over_volt) && state.slot == 3'h0 && !state.phase;
  endsequence

  ready_pin_a: assert property (enable_pin_high |=> ready_lamp)
    else $error("ready lamp dark after enable pin high");
  ready_dark_a: assert property (enable_pin_low |=> !ready_lamp)
    else $error("ready lamp lit after enable pin low");
  ready_phase_a: assert property ((over_temp && state.phase) |=> !ready_lamp)
    else $error("ready lamp lit in dark half of flash");
  power_steady_a: assert property (!(under_volt || over_volt) |=> power_lamp)
    else $error("power lamp dark with supply in limits");
  power_on_a: assert property (blink_start |=> power_lamp)
    else $error("power lamp dark at start of blink pattern");
  power_gap_a: assert property (((under_volt || over_volt) && state.phase) |=> !power_lamp)
    else $error("power lamp lit in dark half of slot");
  power_under_a: assert property ((under_volt && !over_volt && state.slot != 3'h0) |=> !power_lamp)
    else $error("power lamp blinks more than once for undervoltage");
  power_over_a: assert property ((over_volt && state.slot == 3'h1 && !state.phase) |=> power_lamp)
    else $error("power lamp missing second blink for overvoltage");
endmodule // laser_status_ctrl
`default_nettype wire

/* File: design/laser_status_pkg.sv */
// Shared constants for the laser status and enable interface
`default_nettype none
package laser_status_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned BLINK_CYCLES  = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned SYNC_STAGES   = 2;
  // ---------------------------------------------------------------
  // Blink patterns, in blink slots per repeat
  // ---------------------------------------------------------------
  localparam logic [2:0] UNDER_BLINKS   = 3'h1;
  localparam logic [2:0] OVER_BLINKS    = 3'h2;
  localparam logic [2:0] PATTERN_SLOTS  = 3'h6;
  localparam logic       RESET_LEVEL    = 1'b0;
endpackage
`default_nettype wire

/* File: design/input_sync.sv */
// Two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_s;

  sync_s state;
  sync_s next_state;

  always_comb
  begin
    next_state.stage1 = async_in;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.stage2;
endmodule // input_sync
`default_nettype wire

/* File: dv/ctrl_model.sv */
// Machine controller model driving enable and command
`timescale 1ns/1ps
`default_nettype none
module ctrl_model #(
  parameter int unsigned HOLD = 20,
  parameter int unsigned PER  = 10
) (
  // Clock and control
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic pwm_mode,
  // Controller outputs
  output logic      laser_enable,
  output logic      pwm_command
);
  int unsigned hold_cnt;
  int unsigned per_cnt;
  always @(negedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hold_cnt     <= 0;
      per_cnt      <= 0;
      laser_enable <= 1'b0;
      pwm_command  <= 1'b0;
    end
    else
    begin
      if (hold_cnt < HOLD) hold_cnt <= hold_cnt + 1;
      per_cnt      <= (per_cnt == PER - 1) ? 0 : per_cnt + 1;
      laser_enable <= run && (hold_cnt == HOLD);
      pwm_command  <= pwm_mode ? (per_cnt < PER / 2) : (per_cnt == 0);
    end
  end
endmodule // ctrl_model
`default_nettype wire

/* File: dv/laser_status_ctrl_tb.sv */
// Self-checking bench for the laser status block
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      fails++; \
      $display("CHECK FAILED t=%0t %h %h", $time, (a), (b)); \
    end \
  end
module laser_status_ctrl_tb;
  logic       sys_clk = 1'b0, rst = 1'b1, run = 1'b0, pwm_mode = 1'b0, watch_ready = 1'b0;
  logic       over_temp = 1'b0, under_volt = 1'b0, over_volt = 1'b0, lamp_q = 1'b0;
  logic       laser_enable, pwm_command, rf_drive, laser_ok, temp_ok, volt_ok, ready_lamp, power_lamp;
  logic [1:0] hist = 2'h0;
  int         fails = 0, checked = 0, rises = 0, cycles = 0;
  ctrl_model u_ctrl (.sys_clk(sys_clk), .rst(rst), .run(run), .pwm_mode(pwm_mode),
    .laser_enable(laser_enable), .pwm_command(pwm_command));
  laser_status_ctrl #(.BLINK_CYCLES(4)) u_dut (.sys_clk(sys_clk), .rst(rst), .laser_enable(laser_enable),
    .pwm_command(pwm_command), .over_temp(over_temp), .under_volt(under_volt), .over_volt(over_volt),
    .rf_drive(rf_drive), .laser_ok(laser_ok), .temp_ok(temp_ok), .volt_ok(volt_ok),
    .ready_lamp(ready_lamp), .power_lamp(power_lamp));
  initial forever #2.5 sys_clk = ~sys_clk;
  // ------------------------------------------
  // Monitor, timeout and helpers
  // ------------------------------------------
  always @(negedge sys_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      conclude();
    end
    else
    begin
      if (!rst) `chk(rf_drive, hist[1])
      hist   <= {hist[0], laser_enable & pwm_command};
      lamp_q <= watch_ready ? ready_lamp : power_lamp;
      if ((watch_ready ? ready_lamp : power_lamp) && !lamp_q) rises++;
    end
  end
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task count(input int n, output int r);
    rises = 0;
    step(n);
    r = rises;
  endtask
  task conclude();
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    int pu;
    int po;
    int i;
    step(6);
    `chk(({laser_ok, temp_ok, volt_ok, rf_drive}), 4'h0)
    rst = 1'b0;
    step(10);
    run = 1'b1;
    step(5);
    `chk(laser_enable, 1'b0)
    step(100);
    `chk(ready_lamp, 1'b1)
    pwm_mode = 1'b1;
    step(100);
    run = 1'b0;
    step(10);
    `chk(ready_lamp, 1'b0)
    step(40);
    for (i = 0; i < 8; i++)
    begin
      {over_temp, under_volt, over_volt} = i[2:0];
      step(2);
      `chk(({temp_ok, volt_ok, laser_ok}), ({~i[2], ~|i[1:0], ~|i[2:0]}))
    end
    {over_temp, under_volt, over_volt} = 3'h2;
    count(480, pu);
    {over_temp, under_volt, over_volt} = 3'h1;
    count(480, po);
    `chk((pu > 0 && po >= 2 * pu - 3 && po <= 2 * pu + 3), 1'b1)
    `chk((pu >= 9 && pu <= 11), 1'b1)
    {over_temp, under_volt, over_volt} = 3'h0;
    step(2);
    `chk(power_lamp, 1'b1)
    watch_ready = 1'b1;
    over_temp = 1'b1;
    count(100, pu);
    `chk((pu >= 11 && pu <= 14), 1'b1)
    conclude();
  end
endmodule // laser_status_ctrl_tb
`default_nettype wire
